// *** verilog/ddrlp_defs.vh ***
// Constants for the low-power and mode-load sequencer of the DRAM device.
// Assumes inclusion by bare name; definitions only.
`ifndef DDRLP_DEFS_VH
`define DDRLP_DEFS_VH

// ----------------------------------------------------------------------
// Field widths, positions and strobe select encodings
// ----------------------------------------------------------------------
`define DDRLP_ADDR_W        15
`define DDRLP_SS_HI         6
`define DDRLP_SS_LO         5
`define DDRLP_DLL_BIT       0
`define DDRLP_SS_BOTH_DIR   2'h2
`define DDRLP_SS_FREE_RUN   2'h3
`define DDRLP_SS_RESET      2'h2
// ----------------------------------------------------------------------
// Timing counts in link clock cycles
// ----------------------------------------------------------------------
`define DDRLP_CNT_W         16
`define DDRLP_RENEWAL_CYC   16'h0013
`define DDRLP_RECOVERY_CYC  16'h0002
`define DDRLP_SETTLE_CYC    16'h00c8
`define DDRLP_ENTRY_MIN     16'h0000
`define DDRLP_ENTRY_MAX     16'h0002
`define DDRLP_ENTRY_LIMIT   16'h0004

`endif

// *** verilog/ddrlp_seq.v ***
// Low-power, refresh and extended mode load sequencer of the DRAM device.
// Assumes link clock, commands and pins arrive asynchronous to clk_sys,
// link clock slower than a third of clk_sys.
`timescale 1ns/1ps
`include "ddrlp_defs.vh"

module ddrlp_seq
(
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire        linkClk,
    input  wire        chipSel_n,
    input  wire        functionSelect,
    input  wire [1:0]  bankAddr,
    input  wire [14:0] addr,
    input  wire        sleepPin_n,
    output reg         readStrobe_r,
    output reg         readStrobeValid_r,
    output reg         selfRefresh_r,
    output reg         powerDown_r,
    output reg         autoRefresh_r,
    output reg  [1:0]  strobeSelect_r,
    output reg         dllDisabled_r,
    output reg         dllLocked_r
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam ST_IDLE   = 3'h0;
    localparam ST_FIRST  = 3'h1;
    localparam ST_ENTRY  = 3'h2;
    localparam ST_RENEW  = 3'h3;
    localparam ST_SELF   = 3'h4;
    localparam ST_PDOWN  = 3'h5;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    reg [19:0] syncA_r;
    reg [19:0] syncB_r;
    reg        clkPrev_r;
    reg [2:0]  state_r;
    reg [2:0]  state_nxt;
    reg        firstIsWrite_r;
    reg [15:0] entryCnt_r;
    reg [15:0] renewCnt_r;
    reg [15:0] recoverCnt_r;
    reg [15:0] settleCnt_r;

    reg        clkSyncA_r;
    reg        clkNow_r;

    // Edge finder on the synchronised link clock
    function linkEdge;
        input prev;
        input now;
        input wantRise;
        begin
            linkEdge = wantRise ? (~prev & now) : (prev & ~now);
        end
    endfunction

    wire       cs_n   = syncB_r[0];
    wire       fn     = syncB_r[1];
    wire [1:0] ba     = syncB_r[3:2];
    wire [14:0] ad    = syncB_r[18:4];
    wire       sleepN = syncB_r[19];
    wire       rise   = linkEdge(clkPrev_r, clkNow_r, 1'b1);

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Idle pin levels, so reset never fakes a power-down entry
            syncA_r    <= 20'h80001;
            syncB_r    <= 20'h80001;
            clkSyncA_r <= 1'b0;
            clkNow_r   <= 1'b0;
            clkPrev_r  <= 1'b0;
        end
        else
        begin
            syncA_r    <= {sleepPin_n, addr, bankAddr, functionSelect,
                           chipSel_n};
            syncB_r    <= syncA_r;
            clkSyncA_r <= linkClk;
            clkNow_r   <= clkSyncA_r;
            clkPrev_r  <= clkNow_r;
        end
    end

    // ------------------------------------------------------------------
    // Command decode on each link rising edge
    // ------------------------------------------------------------------
    wire selected  = rise & ~cs_n;
    wire firstCmd  = selected & ~fn;
    // A second command only counts right after a first command
    wire secondCmd = selected & fn & (state_r == ST_FIRST);
    wire secondRef = secondCmd & firstIsWrite_r;
    wire extLoad   = secondCmd & ~firstIsWrite_r & (ba == 2'h1);
    wire [1:0] ssField = ad[`DDRLP_SS_HI:`DDRLP_SS_LO];

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (!sleepN)
                    state_nxt = ST_PDOWN;
                else if (firstCmd)
                    state_nxt = ST_FIRST;
            ST_FIRST:
                if (rise)
                    state_nxt = (secondRef && firstIsWrite_r) ? ST_ENTRY
                                                              : ST_IDLE;
            ST_ENTRY:
                if (!sleepN && entryCnt_r <= `DDRLP_ENTRY_MAX)
                    state_nxt = ST_SELF;
                // late fall refreshes, then powers down
                else if (!sleepN)
                    state_nxt = ST_RENEW;
                else if (entryCnt_r > `DDRLP_ENTRY_LIMIT)
                    state_nxt = ST_RENEW;
            ST_RENEW:
                if (renewCnt_r >= `DDRLP_RENEWAL_CYC)
                    state_nxt = sleepN ? ST_IDLE : ST_PDOWN;
            ST_SELF:
                if (sleepN)
                    state_nxt = ST_RENEW;
            ST_PDOWN:
                if (sleepN)
                    state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // State, counters and outputs
    // ------------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r           <= ST_IDLE;
            firstIsWrite_r    <= 1'b0;
            entryCnt_r        <= 16'h0000;
            renewCnt_r        <= 16'h0000;
            recoverCnt_r      <= 16'h0000;
            settleCnt_r       <= 16'h0000;
            readStrobe_r      <= 1'b0;
            readStrobeValid_r <= 1'b0;
            selfRefresh_r     <= 1'b0;
            powerDown_r       <= 1'b0;
            autoRefresh_r     <= 1'b0;
            strobeSelect_r    <= `DDRLP_SS_RESET;
            dllDisabled_r     <= 1'b0;
            dllLocked_r       <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (firstCmd && state_r == ST_IDLE)
                firstIsWrite_r <= ~ad[0];
            if (state_r != ST_ENTRY)
                entryCnt_r <= 16'h0000;
            else if (rise)
                entryCnt_r <= entryCnt_r + 16'h0001;
            if (state_r != ST_RENEW)
                renewCnt_r <= 16'h0000;
            else if (rise)
                renewCnt_r <= renewCnt_r + 16'h0001;
            // strobe invalid over recovery after mode change
            if (extLoad && ssField[1] && ssField != strobeSelect_r)
                recoverCnt_r <= `DDRLP_RECOVERY_CYC;
            else if (rise && recoverCnt_r != 16'h0000)
                recoverCnt_r <= recoverCnt_r - 16'h0001;
            if (extLoad && ssField[1])
                strobeSelect_r <= ssField;
            if (extLoad)
                dllDisabled_r <= ad[`DDRLP_DLL_BIT];
            if (state_r == ST_SELF || extLoad)
            begin
                settleCnt_r <= `DDRLP_SETTLE_CYC;
                dllLocked_r <= 1'b0;
            end
            else if (rise && settleCnt_r != 16'h0000)
                settleCnt_r <= settleCnt_r - 16'h0001;
            else if (settleCnt_r == 16'h0000)
                dllLocked_r <= ~dllDisabled_r;
            selfRefresh_r     <= (state_nxt == ST_SELF);
            powerDown_r       <= (state_nxt == ST_PDOWN);
            autoRefresh_r     <= (state_nxt == ST_RENEW);
            if (strobeSelect_r == `DDRLP_SS_FREE_RUN && state_r != ST_SELF)
                readStrobe_r <= clkNow_r;
            else
                readStrobe_r <= 1'b0;
            // Uses the next state so it drops together with selfRefresh_r
            readStrobeValid_r <= (recoverCnt_r == 16'h0000) &&
                                 (state_nxt != ST_SELF) &&
                                 (strobeSelect_r != `DDRLP_SS_FREE_RUN ||
                                  dllLocked_r);
        end
    end

endmodule

// *** sim/ddrlp_seq_monitor.sv ***
// Checker of sequencer state and strobe outputs.
// Assumes a bind onto ddrlp_seq.
`timescale 1ns/1ps
module ddrlp_seq_chk
(
    input logic       clk_sys,
    input logic       rst_b,
    input logic       sleepPin_n,
    input logic       readStrobe_r,
    input logic       readStrobeValid_r,
    input logic       selfRefresh_r,
    input logic       powerDown_r,
    input logic       autoRefresh_r,
    input logic [1:0] strobeSelect_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_ss; strobeSelect_r[1]; endproperty
    a_ss: assert property (p_ss) else $error("reserved mode");
    property p_rsc;
        $changed(strobeSelect_r) |-> ##[0:2] !readStrobeValid_r;
    endproperty
    a_rsc: assert property (p_rsc) else $error("strobe valid");
    property p_srq; selfRefresh_r |-> !readStrobeValid_r; endproperty
    a_srq: assert property (p_srq) else $error("strobe in sleep");
    property p_excl; !(selfRefresh_r && powerDown_r); endproperty
    a_excl: assert property (p_excl) else $error("two modes");
    property p_ar; $rose(autoRefresh_r) |=> autoRefresh_r [*8]; endproperty
    a_ar: assert property (p_ar) else $error("refresh short");
    property p_qs;
        strobeSelect_r == 2'h2 && $past(strobeSelect_r, 2) == 2'h2
            |-> !readStrobe_r;
    endproperty
    a_qs: assert property (p_qs) else $error("strobe not low");
    property p_sr; $rose(selfRefresh_r) |-> !sleepPin_n; endproperty
    a_sr: assert property (p_sr) else $error("sleep entry");
    property p_pd; $rose(powerDown_r) |-> !sleepPin_n; endproperty
    a_pd: assert property (p_pd) else $error("power-down entry");
    c_sr: cover property ($rose(selfRefresh_r));
    c_pd: cover property ($rose(powerDown_r));
    c_fr: cover property (strobeSelect_r == 2'h3);
endmodule

bind ddrlp_seq ddrlp_seq_chk u_chk
(
    .clk_sys(clk_sys), .rst_b(rst_b), .sleepPin_n(sleepPin_n),
    .readStrobe_r(readStrobe_r), .readStrobeValid_r(readStrobeValid_r),
    .selfRefresh_r(selfRefresh_r), .powerDown_r(powerDown_r),
    .autoRefresh_r(autoRefresh_r), .strobeSelect_r(strobeSelect_r)
);

// *** sim/ddrlp_ctrl_model.sv ***
// Controller model: two-part commands and the sleep pin.
// Assumes a free-running link clock from the bench.
`timescale 1ns/1ps
module ddrlp_ctrl_model
(
    input  logic        linkClk,
    output logic        chipSel_n,
    output logic        functionSelect,
    output logic [1:0]  bankAddr,
    output logic [14:0] addr,
    output logic        sleepPin_n
);
    initial
    begin
        chipSel_n = 1'b1;
        functionSelect = 1'b1;
        bankAddr = 2'h0;
        addr = 15'h0;
        sleepPin_n = 1'b1;
    end
    // second command one link clock later
    task cmd(input logic rd, input logic [1:0] ba, input logic [14:0] a,
             input logic sl);
        @(negedge linkClk);
        chipSel_n = 1'b0;
        functionSelect = 1'b0;
        bankAddr = ba;
        addr = {a[14:1], rd};
        @(negedge linkClk);
        functionSelect = 1'b1;
        addr = a;
        @(negedge linkClk);
        chipSel_n = 1'b1;
        // sleep falls inside the entry window
        sleepPin_n = sl;
        // Released lines show the inverse, not a stale copy
        addr = ~a;
        bankAddr = ~ba;
    endtask
    // clock never stops, so the pin may move any time
    // bench calls it only with no burst in flight
    task sleep(input logic v);
        @(negedge linkClk);
        sleepPin_n = v;
    endtask
endmodule

// *** sim/ddrlp_seq_bench.sv ***
// Self-checking bench of the low-power and mode-load sequencer.
// Assumes the controller model drives the command pins.
`timescale 1ns/1ps
module ddrlp_seq_bench;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        linkClk = 1'b0;
    logic        chipSel_n, functionSelect, sleepPin_n, dll;
    logic [1:0]  bankAddr, strobeSelect_r, ss, ba;
    logic [14:0] addr, a;
    logic        readStrobe_r, readStrobeValid_r, selfRefresh_r;
    logic        powerDown_r, autoRefresh_r, dllDisabled_r, dllLocked_r;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles = 0;
    always #5 clk_sys = ~clk_sys;
    // Offset keeps link edges clear of clk_sys edges
    initial #3 forever #40 linkClk = ~linkClk;
    ddrlp_ctrl_model u_ctrl (.linkClk(linkClk), .chipSel_n(chipSel_n),
        .functionSelect(functionSelect), .bankAddr(bankAddr),
        .addr(addr), .sleepPin_n(sleepPin_n));
    ddrlp_seq dut (.clk_sys(clk_sys), .rst_b(rst_b), .linkClk(linkClk),
        .chipSel_n(chipSel_n), .functionSelect(functionSelect),
        .bankAddr(bankAddr), .addr(addr), .sleepPin_n(sleepPin_n),
        .readStrobe_r(readStrobe_r), .readStrobeValid_r(readStrobeValid_r),
        .selfRefresh_r(selfRefresh_r), .powerDown_r(powerDown_r),
        .autoRefresh_r(autoRefresh_r), .strobeSelect_r(strobeSelect_r),
        .dllDisabled_r(dllDisabled_r), .dllLocked_r(dllLocked_r));
    task test_done;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string n, input logic [1:0] e, input logic [1:0] s);
        comparisons++;
        if (s !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    function logic [1:0] ssNext(input logic [1:0] c, input logic [1:0] b,
                                input logic [1:0] p);
        return (b == 2'h1 && p[1]) ? p : c;
    endfunction
    task links(input int n);
        repeat (n) @(posedge linkClk);
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            test_done();
        end
    end
    initial
    begin
        void'($urandom(32'h0c1d));
        ss = 2'h2;
        dll = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        chk("mode", 2'h2, strobeSelect_r);
        chk("dll", 2'h0, {dllDisabled_r, dllLocked_r});
        links(2);
        // last loads leave the DLL on
        // refreshes and sleeps stay sparse and short
        for (int i = 0; i < 8; i++)
        begin
            ba = (i < 4) ? 2'h1 : 2'($urandom_range(0, 3));
            a = 15'($urandom);
            a = {a[14:7], 2'(i), 4'h0, 1'(i == 2)};
            if (ba == 2'h1)
                dll = a[0];
            ss = ssNext(ss, ba, a[6:5]);
            u_ctrl.cmd(1'b1, ba, a, 1'b1);
            links(8);
            chk("mode", ss, strobeSelect_r);
            @(negedge linkClk);
            chk("strobe", {1'b0, ss == 2'h3}, {1'b0, readStrobe_r});
            chk("dll", {1'b0, dll}, {1'b0, dllDisabled_r});
        end
        u_ctrl.cmd(1'b0, 2'h0, 15'($urandom), 1'b1);
        links(10);
        chk("refresh", 2'h2, {autoRefresh_r, selfRefresh_r});
        links(20);
        chk("renewal", 2'h0, {autoRefresh_r, powerDown_r});
        u_ctrl.cmd(1'b0, 2'h0, 15'($urandom), 1'b0);
        links(10);
        chk("sleep", 2'h2, {selfRefresh_r, powerDown_r});
        chk("valid", 2'h0, {1'b0, readStrobeValid_r});
        u_ctrl.sleep(1'b1);
        links(20);
        chk("exit", 2'h0, {selfRefresh_r, powerDown_r});
        u_ctrl.cmd(1'b0, 2'h0, 15'($urandom), 1'b1);
        links(210);
        chk("relock", 2'h3, {dllLocked_r, readStrobeValid_r});
        u_ctrl.cmd(1'b0, 2'h0, 15'($urandom), 1'b1);
        links(6 + $urandom_range(0, 3));
        u_ctrl.sleep(1'b0);
        links(30);
        chk("late", 2'h2, {powerDown_r, selfRefresh_r});
        u_ctrl.sleep(1'b1);
        links(4);
        chk("wake", 2'h0, {powerDown_r, selfRefresh_r});
        u_ctrl.sleep(1'b0);
        links(4);
        chk("pdown", 2'h2, {powerDown_r, selfRefresh_r});
        u_ctrl.sleep(1'b1);
        links(4);
        chk("idle", 2'h0, {powerDown_r, selfRefresh_r});
        test_done();
    end
endmodule
